/* logic/bt_pwr_pkg.sv */
// package: constants, register map and states of the bluetooth power handshake block
package bt_pwr_pkg;
  localparam int unsigned CLK_HZ = 100_000_000;
  localparam logic [7:0] OFF_CTRL     = 8'h00;
  localparam logic [7:0] OFF_RFCTL    = 8'h04;
  localparam logic [7:0] OFF_SLEEPINT = 8'h08;
  localparam logic [7:0] OFF_STATUS   = 8'h0c;
  localparam logic [7:0] OFF_IRQSTAT  = 8'h10;
  localparam logic [7:0] OFF_IRQMASK  = 8'h14;
  localparam logic [7:0] OFF_BURST    = 8'h18;
  // ctrl fields
  localparam int CTRL_UART      = 0;
  localparam int CTRL_HSK_EN    = 1;
  localparam int CTRL_DW_POL    = 2;
  localparam int CTRL_HW_POL    = 3;
  localparam int CTRL_SLEEP_OK  = 4;
  localparam int CTRL_LOWPWR    = 5;
  localparam int CTRL_SHUTDOWN  = 6;
  localparam int CTRL_WLAN_CLK  = 7;
  localparam int CTRL_PADFN_LO  = 8;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0001;
  localparam logic [15:0] SLEEPINT_RESET = 16'h0020;
  localparam logic [7:0] BURST_RESET = 8'h04;
  // irq bits
  localparam int IRQ_WAKE    = 0;
  localparam int IRQ_SLEEP   = 1;
  localparam int IRQ_TIMER   = 2;
  localparam int IRQ_BURST   = 3;
  localparam int IRQ_W       = 4;
  localparam logic [2:0] PADFN_HANDSHAKE = 3'h0;
  localparam int unsigned WAIT_CYCLES = 1;
  typedef enum logic [2:0] {ST_ACTIVE, ST_SLEEP, ST_SHUTDOWN} pwr_state_e;
endpackage

/* logic/bt_wake_sync.sv */
// two flip-flop synchroniser for the device-wake pin
module bt_wake_sync (
  input  wire logic core_clk,
  input  wire logic arst_n,
  input  wire logic asyncIn,
  output logic      syncOut
);
  logic stage1_q;
  logic stage2_q;
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      stage1_q <= 1'b0;
      stage2_q <= 1'b0;
    end else begin
      stage1_q <= asyncIn;
      stage2_q <= stage1_q;
    end
  end
  assign syncOut = stage2_q;
endmodule

/* logic/bt_power_handshake.sv */
// bluetooth power manager: radio power-down, host wake handshake, sleep, shutdown
// What this block does
// - drive separate power-down lines for tx, rx, pll and power amplifier
// - power actions come from register writes and from packet events
// - wake and clock-request lines work only in uart mode when enabled
// - asserted device-wake forces wake or prevents sleep
// - deasserted device-wake permits sleep once internal criteria are met
// - device-wake and host-wake polarities each selectable by software
// - host-wake asserted when device needs host; host must stay awake
// - refclk request high when bluetooth or wlan needs reference clock
// - pad function of handshake pins held at zero
// - radio powered only inside tx and rx packets
// - low-power link modes run on slow oscillator and wake on timer
// - shutdown tristates all outputs and disables inputs except dataPush, which still counts into the burst buffer
// - leaving shutdown equals power-up, nothing retained
// - outgoing data buffered and sent in bursts so host sleeps longer
//
// Our own choices: the Avalon-MM slave port and the register offsets.
module bt_power_handshake
  import bt_pwr_pkg::*;
(
  input  wire logic        core_clk,
  input  wire logic        arst_n,
  input  wire logic [7:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic [31:0]      avs_readdata,
  output logic             avs_waitrequest,
  output logic             irq,
  input  wire logic        lpoTick,
  input  wire logic        devWakeIn,
  input  wire logic        txPacket,
  input  wire logic        rxPacket,
  input  wire logic        hostPending,
  input  wire logic        dataPush,
  output logic             hostWakeOut,
  output logic             hostWakeOe,
  output logic             btRefclkReq,
  output logic             wlanRefclkReq,
  output logic             refclkOe,
  output logic             txPd,
  output logic             rxPd,
  output logic             pllPd,
  output logic             paPd,
  output logic             useLowPowerOsc,
  output logic             burstSend,
  output logic [2:0]       padFunction,
  output logic             coreAwake
);
  // ****************************************
  // registers
  // ****************************************
  logic [31:0] ctrl_q, ctrl_d;
  logic [3:0]  rfForce_q, rfForce_d;
  logic [15:0] sleepInt_q, sleepInt_d;
  logic [15:0] timer_q, timer_d;
  logic [IRQ_W-1:0] irqStat_q, irqStat_d, irqMask_q, irqMask_d;
  logic [7:0]  burstThr_q, burstThr_d, burstCnt_q, burstCnt_d;
  logic [31:0] rdata_q, rdata_d;
  logic        ack_q, ack_d;
  pwr_state_e  state_q, state_d;
  logic        hwOut_q, hwOut_d, hwOe_q, hwOe_d, btReq_q, btReq_d, wlReq_q, wlReq_d;
  logic        refOe_q, refOe_d, burst_q, burst_d, lpo_q, lpo_d, awake_q, awake_d;
  logic [3:0]  pd_q, pd_d;
  logic        devWakeSync, devWakeAct, hskOn;
  logic [IRQ_W-1:0] events;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) r[i*8 +: 8] = nw[i*8 +: 8];
    end
    return r;
  endfunction

  bt_wake_sync u_sync (
    .core_clk (core_clk),
    .arst_n   (arst_n),
    .asyncIn  (devWakeIn),
    .syncOut  (devWakeSync)
  );

  always_comb begin
    hskOn = ctrl_q[CTRL_UART] && ctrl_q[CTRL_HSK_EN];
    devWakeAct = hskOn && (devWakeSync ^ ctrl_q[CTRL_DW_POL]);
  end

  // ****************************************
  // bus slave and power control
  // ****************************************
  always_comb begin
    logic wr, rd, timerHit;
    // a write lands only at the edge that shows waitrequest low
    wr = avs_write && ack_q;
    rd = avs_read && !ack_q;
    timerHit = 1'b0;
    ctrl_d = ctrl_q;
    rfForce_d = rfForce_q;
    sleepInt_d = sleepInt_q;
    irqMask_d = irqMask_q;
    burstThr_d = burstThr_q;
    rdata_d = rdata_q;
    ack_d = (avs_read || avs_write) && !ack_q;
    events = '0;
    state_d = state_q;
    timer_d = timer_q;
    burstCnt_d = burstCnt_q;
    burst_d = 1'b0;
    if (wr) begin
      case (avs_address)
        OFF_CTRL:     ctrl_d = merge(ctrl_q, avs_writedata, avs_byteenable);
        OFF_RFCTL:    rfForce_d = avs_writedata[3:0];
        OFF_SLEEPINT: sleepInt_d = avs_writedata[15:0];
        OFF_IRQMASK:  irqMask_d = avs_writedata[IRQ_W-1:0];
        OFF_BURST:    burstThr_d = avs_writedata[7:0];
        default:      ;
      endcase
    end
    if (rd) begin
      case (avs_address)
        OFF_CTRL:     rdata_d = ctrl_q;
        OFF_RFCTL:    rdata_d = {28'h0, rfForce_q};
        OFF_SLEEPINT: rdata_d = {16'h0, sleepInt_q};
        OFF_STATUS:   rdata_d = {24'h0, burstCnt_q[3:0], 1'b0, 3'(state_q)};
        OFF_IRQSTAT:  rdata_d = {28'h0, irqStat_q};
        OFF_IRQMASK:  rdata_d = {28'h0, irqMask_q};
        OFF_BURST:    rdata_d = {24'h0, burstThr_q};
        default:      rdata_d = 32'h0;
      endcase
    end
    case (state_q)
      ST_ACTIVE: begin
        if (!devWakeAct && ctrl_q[CTRL_SLEEP_OK] && !hostPending) begin
          state_d = ST_SLEEP;
          timer_d = sleepInt_q;
          events[IRQ_SLEEP] = 1'b1;
        end
      end
      ST_SLEEP: begin
        if (lpoTick && timer_q != 16'h0) timer_d = timer_q - 16'h1;
        timerHit = lpoTick && timer_q <= 16'h1;
        if (devWakeAct || timerHit || hostPending) begin
          state_d = ST_ACTIVE;
          events[IRQ_WAKE] = 1'b1;
          events[IRQ_TIMER] = timerHit;
        end
      end
      ST_SHUTDOWN: ;
      default: state_d = ST_ACTIVE;
    endcase
    if (state_q == ST_ACTIVE && burstCnt_q != 8'h0) begin
      burst_d = 1'b1;
      burstCnt_d = 8'h0;
    end else if (dataPush && burstCnt_q != 8'hff) begin
      burstCnt_d = burstCnt_q + 8'h1;
      if (burstCnt_q + 8'h1 >= burstThr_q) begin
        events[IRQ_BURST] = 1'b1;
        if (state_q == ST_SLEEP) state_d = ST_ACTIVE;
      end
    end
    if (ctrl_q[CTRL_SHUTDOWN]) state_d = ST_SHUTDOWN;
    if (state_q == ST_SHUTDOWN && !ctrl_q[CTRL_SHUTDOWN]) begin
      state_d = ST_ACTIVE;
      ctrl_d = CTRL_RESET;
      rfForce_d = '0;
      sleepInt_d = SLEEPINT_RESET;
      irqMask_d = '0;
      burstThr_d = BURST_RESET;
      burstCnt_d = 8'h0;
      timer_d = '0;
    end
    // sticky status: set beats read-clear
    irqStat_d = irqStat_q | events;
    if (rd && avs_address == OFF_IRQSTAT) irqStat_d = events;
    if (state_q == ST_SHUTDOWN && !ctrl_q[CTRL_SHUTDOWN]) irqStat_d = '0;
  end

  // ****************************************
  // pin outputs
  // ****************************************
  always_comb begin
    logic off;
    off = state_d == ST_SHUTDOWN;
    // host wake, polarity taken from the same register copy as the gate
    hwOut_d = (hskOn && hostPending) ^ ctrl_q[CTRL_HW_POL];
    hwOe_d = hskOn && !off;
    btReq_d = hskOn && !off && state_d == ST_ACTIVE;
    wlReq_d = hskOn && !off && ctrl_d[CTRL_WLAN_CLK];
    refOe_d = hskOn && !off;
    pd_d[0] = off || state_d != ST_ACTIVE || !txPacket || rfForce_d[0];
    pd_d[1] = off || state_d != ST_ACTIVE || !rxPacket || rfForce_d[1];
    pd_d[2] = off || state_d != ST_ACTIVE || !(txPacket || rxPacket) || rfForce_d[2];
    pd_d[3] = off || state_d != ST_ACTIVE || !txPacket || rfForce_d[3];
    lpo_d = state_d == ST_SLEEP && ctrl_d[CTRL_LOWPWR];
    awake_d = state_d == ST_ACTIVE;
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      ctrl_q <= CTRL_RESET;
      rfForce_q <= '0;
      sleepInt_q <= SLEEPINT_RESET;
      timer_q <= '0;
      irqStat_q <= '0;
      irqMask_q <= '0;
      burstThr_q <= BURST_RESET;
      burstCnt_q <= '0;
      rdata_q <= '0;
      ack_q <= 1'b0;
      state_q <= ST_ACTIVE;
      hwOut_q <= 1'b0;
      hwOe_q <= 1'b0;
      btReq_q <= 1'b0;
      wlReq_q <= 1'b0;
      refOe_q <= 1'b0;
      pd_q <= 4'hf;
      burst_q <= 1'b0;
      lpo_q <= 1'b0;
      awake_q <= 1'b0;
    end else begin
      ctrl_q <= ctrl_d;
      rfForce_q <= rfForce_d;
      sleepInt_q <= sleepInt_d;
      timer_q <= timer_d;
      irqStat_q <= irqStat_d;
      irqMask_q <= irqMask_d;
      burstThr_q <= burstThr_d;
      burstCnt_q <= burstCnt_d;
      rdata_q <= rdata_d;
      ack_q <= ack_d;
      state_q <= state_d;
      hwOut_q <= hwOut_d;
      hwOe_q <= hwOe_d;
      btReq_q <= btReq_d;
      wlReq_q <= wlReq_d;
      refOe_q <= refOe_d;
      pd_q <= pd_d;
      burst_q <= burst_d;
      lpo_q <= lpo_d;
      awake_q <= awake_d;
    end
  end

  logic irq_q;
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) irq_q <= 1'b0;
    else irq_q <= |(irqStat_d & irqMask_d);
  end

  assign avs_readdata = rdata_q;
  assign avs_waitrequest = (avs_read || avs_write) && !ack_q;
  assign irq = irq_q;
  assign hostWakeOut = hwOut_q;
  assign hostWakeOe = hwOe_q;
  assign btRefclkReq = btReq_q;
  assign wlanRefclkReq = wlReq_q;
  assign refclkOe = refOe_q;
  assign {paPd, pllPd, rxPd, txPd} = pd_q;
  assign useLowPowerOsc = lpo_q;
  assign burstSend = burst_q;
  assign padFunction = PADFN_HANDSHAKE;
  assign coreAwake = awake_q;

  // ****************************************
  // assertions
  // ****************************************
  property p_wake_no_sleep;
    @(posedge core_clk) disable iff (!arst_n)
      devWakeAct && !ctrl_q[CTRL_SHUTDOWN] |=> state_q != ST_SLEEP;
  endproperty
  a_wake_no_sleep: assert property (p_wake_no_sleep) else $error("slept while woken");

  property p_sleep_crit;
    @(posedge core_clk) disable iff (!arst_n)
      state_q == ST_ACTIVE ##1 state_q == ST_SLEEP |-> $past(ctrl_q[CTRL_SLEEP_OK]);
  endproperty
  a_sleep_crit: assert property (p_sleep_crit) else $error("sleep without criteria");

  property p_gate;
    @(posedge core_clk) disable iff (!arst_n)
      !hskOn |=> !btRefclkReq && !hostWakeOe;
  endproperty
  a_gate: assert property (p_gate) else $error("handshake outside uart");

  property p_hostwake;
    @(posedge core_clk) disable iff (!arst_n)
      hskOn && hostPending && !ctrl_q[CTRL_HW_POL] && $stable(ctrl_q) |=> hostWakeOut;
  endproperty
  a_hostwake: assert property (p_hostwake) else $error("host wake missing");

  property p_shut;
    @(posedge core_clk) disable iff (!arst_n)
      state_q == ST_SHUTDOWN |-> !hostWakeOe && !refclkOe && txPd && paPd;
  endproperty
  a_shut: assert property (p_shut) else $error("output driven in shutdown");

  property p_radio;
    @(posedge core_clk) disable iff (!arst_n)
      !txPd |-> $past(txPacket) && state_q == ST_ACTIVE;
  endproperty
  a_radio: assert property (p_radio) else $error("tx powered outside packet");

  property p_lpo;
    @(posedge core_clk) disable iff (!arst_n)
      useLowPowerOsc |-> state_q == ST_SLEEP;
  endproperty
  a_lpo: assert property (p_lpo) else $error("slow osc while active");

  property p_irq;
    @(posedge core_clk) disable iff (!arst_n)
      $rose(irqStat_q[IRQ_TIMER]) && irqMask_q[IRQ_TIMER] |-> irq;
  endproperty
  a_irq: assert property (p_irq) else $error("irq missed");
endmodule

/* test/bt_host_model.sv */
// host processor model: drives device-wake, obeys host-wake and clock request
module bt_host_model (
  input  wire logic core_clk,
  input  wire logic needDevice,
  input  wire logic devWakeLow,
  input  wire logic hostWakePin,
  input  wire logic hostWakeLow,
  input  wire logic refclkReq,
  output logic      devWakePin,
  output logic      hostAwake,
  output logic      refclkOn
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] idleCnt;
  initial begin
    devWakePin = 1'b0;
    hostAwake = 1'b1;
    refclkOn = 1'b0;
    idleCnt = 2'd0;
  end
  always @(posedge core_clk) begin
    devWakePin <= needDevice ^ devWakeLow;
    if ((hostWakePin ^ hostWakeLow) || needDevice) begin
      hostAwake <= 1'b1;
      idleCnt <= 2'd0;
    end else if (idleCnt == 2'd3) begin
      hostAwake <= 1'b0;
    end else begin
      idleCnt <= idleCnt + 2'd1;
    end
    refclkOn <= refclkReq;
  end
endmodule

/* test/bt_power_handshake_test.sv */
// testbench: register bus, radio power-down, wake handshake, sleep, shutdown
module bt_power_handshake_test;
  import bt_pwr_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk, arst_n, avs_read, avs_write, avs_waitrequest, irq, lpoTick, devWakeIn;
  logic txPacket, rxPacket, hostPending, dataPush, hostWakeOut, hostWakeOe, btRefclkReq;
  logic wlanRefclkReq, refclkOe, txPd, rxPd, pllPd, paPd, useLowPowerOsc, burstSend, coreAwake;
  logic need, dwLow, hwLow, hostAwake, refclkOn;
  logic [7:0]  avs_address;
  logic [31:0] avs_writedata, avs_readdata, seed, monE, monM, rdq;
  logic [3:0]  avs_byteenable;
  logic [2:0]  padFunction;
  logic [13:0] pinVec;
  logic [31:0] expQ[$];
  logic [31:0] mskQ[$];
  int          bad_count, checks_done, i;
  bt_power_handshake dut_u (.core_clk(core_clk), .arst_n(arst_n), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .irq(irq), .lpoTick(lpoTick), .devWakeIn(devWakeIn),
    .txPacket(txPacket), .rxPacket(rxPacket), .hostPending(hostPending), .dataPush(dataPush),
    .hostWakeOut(hostWakeOut), .hostWakeOe(hostWakeOe), .btRefclkReq(btRefclkReq),
    .wlanRefclkReq(wlanRefclkReq), .refclkOe(refclkOe), .txPd(txPd), .rxPd(rxPd),
    .pllPd(pllPd), .paPd(paPd), .useLowPowerOsc(useLowPowerOsc), .burstSend(burstSend),
    .padFunction(padFunction), .coreAwake(coreAwake));
  bt_host_model host_u (.core_clk(core_clk), .needDevice(need), .devWakeLow(dwLow),
    .hostWakePin(hostWakeOut), .hostWakeLow(hwLow), .refclkReq(btRefclkReq | wlanRefclkReq),
    .devWakePin(devWakeIn), .hostAwake(hostAwake), .refclkOn(refclkOn));
  assign pinVec = {burstSend, padFunction === 3'h0, coreAwake, irq, useLowPowerOsc, paPd,
                   pllPd, rxPd, txPd, refclkOe, wlanRefclkReq, btRefclkReq, hostWakeOe,
                   hostWakeOut};
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  function logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  task conclude();
    if (bad_count == 0 && checks_done > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // request held until the edge that samples waitrequest low
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    int n;
    @(posedge core_clk);
    avs_address <= a;
    avs_write <= w;
    avs_read <= !w;
    avs_writedata <= d;
    for (n = 0; n < 50; n++) begin
      @(posedge core_clk);
      if (avs_waitrequest === 1'b0) break;
    end
    if (n == 50) begin
      bad_count++;
      conclude();
    end
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d, rdq);
  endtask
  // a zero mask marks a poll that the monitor passes over
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
    expQ.push_back(e);
    mskQ.push_back(m);
    bus(1'b0, a, 32'h0, rdq);
  endtask
  task automatic wait_state(input logic [2:0] s);
    int n;
    for (n = 0; n < 40; n++) begin
      rd(OFF_STATUS, 32'h0, 32'h0);
      if (rdq[2:0] === s) break;
    end
    rd(OFF_STATUS, {29'h0, s}, 32'h7);
    if (n == 40) begin
      bad_count++;
      conclude();
    end
  endtask
  task automatic pin(input int k, input logic e);
    int n;
    for (n = 0; n < 60; n++) begin
      @(posedge core_clk);
      if (pinVec[k] === e) break;
    end
    checks_done++;
    if (pinVec[k] !== e) begin
      $display("wrong value pin %0d expected %b seen %b", k, e, pinVec[k]);
      bad_count++;
      conclude();
    end
  endtask
  task automatic chk(input string nm, input logic e, input logic g);
    checks_done++;
    if (g !== e) begin
      $display("wrong value %s expected %b seen %b", nm, e, g);
      bad_count++;
    end
  endtask
  always @(posedge core_clk) begin
    if (avs_read === 1'b1 && avs_waitrequest === 1'b0 && mskQ.size() > 0) begin
      monE = expQ.pop_front();
      monM = mskQ.pop_front();
      if (monM != 32'h0) begin
        checks_done++;
        if ((avs_readdata & monM) !== monE) begin
          $display("wrong value reg %h expected %h seen %h", avs_address, monE, avs_readdata);
          bad_count++;
        end
      end
    end
  end
  initial begin
    {arst_n, avs_read, avs_write, lpoTick, txPacket, rxPacket, hostPending, dataPush} = 8'h00;
    {need, dwLow, hwLow} = 3'h0;
    avs_address = 8'h00;
    avs_writedata = 32'h0;
    avs_byteenable = 4'hf;
    seed = 32'h636e1229;
    bad_count = 0;
    checks_done = 0;
    repeat (20) @(posedge core_clk);
    arst_n <= 1'b1;
    pin(12, 1'b1);
    pin(5, 1'b1);
    rd(OFF_CTRL, CTRL_RESET, 32'hffffffff);
    rd(OFF_SLEEPINT, {16'h0, SLEEPINT_RESET}, 32'hffffffff);
    rd(OFF_BURST, {24'h0, BURST_RESET}, 32'hffffffff);
    rd(8'h1c, 32'h0, 32'hffffffff);
    avs_byteenable <= 4'he;
    wr(OFF_CTRL, 32'hffffff00);
    avs_byteenable <= 4'hf;
    rd(OFF_CTRL, 32'hffffff01, 32'hffffffff);
    txPacket <= 1'b1;
    rxPacket <= 1'b1;
    wr(OFF_RFCTL, 32'h0);
    pin(5, 1'b0);
    pin(6, 1'b0);
    for (i = 0; i < 4; i++) begin
      wr(OFF_RFCTL, 32'h1 << i);
      pin(5 + i, 1'b1);
    end
    wr(OFF_RFCTL, 32'h0);
    txPacket <= 1'b0;
    rxPacket <= 1'b0;
    pin(6, 1'b1);
    wr(OFF_CTRL, 32'h11);
    pin(1, 1'b0);
    wr(OFF_CTRL, 32'h12);
    pin(1, 1'b0);
    for (i = 0; i < 4; i++) begin
      dwLow <= i[0];
      hwLow <= i[1];
      need <= 1'b1;
      wr(OFF_CTRL, 32'h13 | (i << 2));
      wait_state(3'h0);
      need <= 1'b0;
      wait_state(3'h1);
      hostPending <= 1'b1;
      pin(0, !i[1]);
      pin(1, 1'b1);
      @(posedge core_clk);
      chk("hostAwake", 1'b1, hostAwake);
      hostPending <= 1'b0;
      pin(0, i[1]);
    end
    // back to plain polarities, host keeps the device awake meanwhile
    dwLow <= 1'b0;
    hwLow <= 1'b0;
    need <= 1'b1;
    wr(OFF_CTRL, 32'h93);
    wait_state(3'h0);
    pin(2, 1'b1);
    pin(3, 1'b1);
    pin(4, 1'b1);
    @(posedge core_clk);
    chk("refclkOn", 1'b1, refclkOn);
    wr(OFF_IRQMASK, 32'h4);
    wr(OFF_SLEEPINT, 32'h3);
    wr(OFF_CTRL, 32'h33);
    // the interval is loaded on sleep entry, so enter sleep after setting it
    need <= 1'b0;
    wait_state(3'h1);
    pin(9, 1'b1);
    pin(2, 1'b0);
    for (i = 0; i < 3; i++) begin
      chk("irq", 1'b0, irq);
      lpoTick <= 1'b1;
      @(posedge core_clk);
      lpoTick <= 1'b0;
      repeat (rnd() % 4 + 1) @(posedge core_clk);
    end
    pin(10, 1'b1);
    need <= 1'b1;
    wait_state(3'h0);
    rd(OFF_IRQSTAT, 32'h4, 32'h4);
    pin(10, 1'b0);
    rd(OFF_IRQSTAT, 32'h0, 32'h4);
    need <= 1'b0;
    wr(OFF_BURST, 32'h2);
    wr(OFF_CTRL, 32'h13);
    wait_state(3'h1);
    dataPush <= 1'b1;
    @(posedge core_clk);
    dataPush <= 1'b0;
    @(posedge core_clk);
    dataPush <= 1'b1;
    @(posedge core_clk);
    dataPush <= 1'b0;
    pin(13, 1'b1);
    seed = rnd();
    wr(OFF_SLEEPINT, {16'h0, seed[15:0]});
    rd(OFF_SLEEPINT, {16'h0, seed[15:0]}, 32'hffff);
    wr(OFF_CTRL, 32'h53);
    wait_state(3'h2);
    pin(1, 1'b0);
    pin(4, 1'b0);
    wr(OFF_CTRL, 32'h01);
    rd(OFF_CTRL, CTRL_RESET, 32'hffffffff);
    rd(OFF_SLEEPINT, {16'h0, SLEEPINT_RESET}, 32'hffffffff);
    rd(OFF_BURST, {24'h0, BURST_RESET}, 32'hffffffff);
    rd(OFF_IRQSTAT, 32'h0, 32'hf);
    conclude();
  end
endmodule
